// >>> verilog/jcu_map.vh
// register offsets, field positions and reset values of the compression
// control block; included by the block's design file.
`ifndef JCU_MAP_VH
`define JCU_MAP_VH

`define JCU_OFF_CTRL 16'h1E80
`define JCU_OFF_SHARE 16'h1E84
`define JCU_OFF_CEIL 16'h1E8C
`define JCU_OFF_SETCMD 16'h1E90
`define JCU_OFF_SETSTAT 16'h1E94
`define JCU_OFF_SETDATA 16'h1E98

// bit 0 is the field's top bit in the printed numbering, i.e. bus bit 31
`define JCU_PRES_BIT 31
`define JCU_RTP_BIT 30
`define JCU_ON_BIT 25
`define JCU_AM_BIT 24
`define JCU_QUAL_HI 7
`define JCU_QUAL_LO 0
`define JCU_V7_HI 6
`define JCU_V7_LO 0

`define JCU_SHARE_ZERO_SUB 7'h66
`define JCU_QUAL_ZERO_SUB 8'h3C
`define JCU_CEIL_RESET 7'h66
`define JCU_QUAL_RESET 8'h00

`define JCU_NSETS 3
`define JCU_NSAVED 8
`endif

// >>> verilog/jcu_regs.v
// compression control registers and user set save and restore, behind an
// AXI4-Lite slave. assumes one clock, a synchronous active-low reset and a
// master that keeps at most one write and one read outstanding.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "jcu_map.vh"

// How it works
// RULE_01: top bit of each compression register reads 1, feature present.
// RULE_02: buffer share register gives host buffer percent for compressed data.
// RULE_03: share value in bits 25-31, codes 0x00-0x7F map to 0-100 percent.
// RULE_04: share value zero acts as code 0x66, eighty percent.
// RULE_05: control bit 1 turns RTP transmission on or off.
// RULE_06: control bit 6 switches compression; reads show present state.
// RULE_07: with compression off, other control fields ignore writes.
// RULE_08: control bit 7 picks manual or automatic quality; reads show mode.
// RULE_09: quality field bits 24-31, codes 0x01-0x64 mean 1-100 percent.
// RULE_10: quality zero acts as sixty percent.
// RULE_11: in automatic mode writes to quality are discarded.
// RULE_12: ceiling register bits 25-31 limit automatic quality.
// RULE_13: ceiling resets to eighty percent.
// RULE_14: software should keep the ceiling at or below eighty percent.
// RULE_15: user set zero holds factory defaults, never overwritten.
// RULE_16: two writable user sets store custom defaults.
// RULE_17: at reset and on reinit, load the most recently saved set. Reset here clears last_saved_reg, so a reset always loads set zero.
// RULE_18: saving to set zero selects factory defaults for next init.
// RULE_19: a save stores the listed configuration registers.
// RULE_20: reserved bits read zero and ignore writes.
module jcu_regs #(
  parameter AUTO_QUAL_INIT = 8'h3C
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // automatic quality engine
  input wire [7:0] auto_quality,
  // settings seen by the rest of the camera
  output reg compression_enable,
  output reg rtp_transmit_enable,
  output reg auto_quality_mode,
  output reg [7:0] quality_effective,
  output reg [6:0] buffer_share_effective,
  output reg [6:0] quality_ceiling,
  // configuration registers kept in user sets
  input wire [32*`JCU_NSAVED-1:0] config_live,
  output reg [32*`JCU_NSAVED-1:0] config_restore,
  output reg config_restore_load
);

  localparam NS = `JCU_NSETS;
  localparam NW = `JCU_NSAVED;
  localparam [1:0] OKAY = 2'b00;
  localparam [1:0] SLVERR = 2'b10;

  // factory contents of set zero; fixed, so it can never be overwritten
  localparam [32*`JCU_NSAVED-1:0] FACTORY = {32*`JCU_NSAVED{1'b0}};

  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          lane_merge[k*8 +: 8] = din[k*8 +: 8];
    end
  endfunction

  function known_addr;
    input [15:0] a;
    begin
      if (a == `JCU_OFF_CTRL)
        known_addr = 1'b1;
      else if (a == `JCU_OFF_SHARE)
        known_addr = 1'b1;
      else if (a == `JCU_OFF_CEIL)
        known_addr = 1'b1;
      else if (a == `JCU_OFF_SETCMD)
        known_addr = 1'b1;
      else if (a == `JCU_OFF_SETSTAT)
        known_addr = 1'b1;
      else if (a == `JCU_OFF_SETDATA)
        known_addr = 1'b1;
      else
        known_addr = 1'b0;
    end
  endfunction

  // control word as it reads back; reserved ranges are tied to zero
  function [31:0] ctrl_word;
    input rtp;
    input on;
    input am;
    input [7:0] q;
    begin
      ctrl_word = {1'b1, rtp, 4'h0, on, am, 16'h0000, q};
    end
  endfunction

  // byte-lane merge of a 7-bit value field; the upper lanes are reserved
  function [6:0] val7_merge;
    input [6:0] old;
    input [31:0] din;
    input [3:0] strb;
    reg [31:0] m;
    begin
      m = lane_merge({25'h0000000, old}, din, strb);
      val7_merge = m[`JCU_V7_HI:`JCU_V7_LO];
    end
  endfunction

  // ceiling code (0x7F is full scale) to whole percent, rounded down;
  // the product needs 14 bits before the divide
  function [7:0] ceil_pct;
    input [6:0] code;
    reg [13:0] prod;
    reg [13:0] quo;
    begin
      prod = {7'h00, code} * 14'd100;
      quo = prod / 14'd127;
      ceil_pct = quo[7:0];
    end
  endfunction

  // first word of a writable set in the shared array; set zero has none
  function integer set_base;
    input [1:0] ch;
    begin
      set_base = (ch - 2'd1) * NW;
    end
  endfunction

  // stored fields
  reg rtp_reg;
  reg on_reg;
  reg am_reg;
  reg [7:0] qual_reg;
  reg [6:0] share_reg;
  reg [6:0] ceil_reg;
  reg [1:0] last_saved_reg;
  reg [1:0] data_idx_reg;
  reg init_pend_reg;
  reg [31:0] set_mem [0:(NS-1)*NW-1];

  // write channel capture: address and data accepted in either order
  reg aw_held_reg;
  reg w_held_reg;
  reg [15:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_now = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  wire w_now = w_held_reg || (s_axi_wvalid && s_axi_wready);
  wire [15:0] wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_go = aw_now && w_now && !s_axi_bvalid;

  wire [31:0] ctrl_img = ctrl_word(rtp_reg, on_reg, am_reg,
    qual_reg); // RULE_01 RULE_20
  wire [31:0] wm = lane_merge(ctrl_img, wd, ws);

  // set-command register: bits 1:0 channel, bit 8 save, bit 9 reinit
  wire cmd_hit = wr_go && (wa == `JCU_OFF_SETCMD);
  wire [31:0] cmd_w = lane_merge(32'h00000000, wd, ws);
  wire save_go = cmd_hit && cmd_w[8] && (cmd_w[1:0] < NS);
  wire reinit_go = cmd_hit && cmd_w[9];

  // separate loop variables so no variable is written by two processes
  integer i;
  integer j;

  // value-field writes, merged per byte lane before they land
  wire [6:0] share_m = val7_merge(share_reg, wd, ws);
  wire [6:0] ceil_m = val7_merge(ceil_reg, wd, ws);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 16'h0000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_addr(wa) ? OKAY : SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register updates
  always @(posedge aclk) begin
    if (!aresetn) begin
      rtp_reg <= 1'b0;
      on_reg <= 1'b0;
      am_reg <= 1'b0;
      qual_reg <= `JCU_QUAL_RESET;
      share_reg <= 7'h00;
      ceil_reg <= `JCU_CEIL_RESET; // RULE_13
      data_idx_reg <= 2'b00;
      init_pend_reg <= 1'b1; // RULE_17
    end else begin
      init_pend_reg <= reinit_go; // RULE_17
      if (wr_go && wa == `JCU_OFF_CTRL) begin
        on_reg <= wm[`JCU_ON_BIT]; // RULE_06
        if (on_reg) begin // RULE_07
          rtp_reg <= wm[`JCU_RTP_BIT]; // RULE_05
          am_reg <= wm[`JCU_AM_BIT]; // RULE_08
          if (!am_reg)
            qual_reg <= wm[`JCU_QUAL_HI:`JCU_QUAL_LO]; // RULE_09 RULE_11
        end
      end
      if (wr_go && wa == `JCU_OFF_SHARE)
        share_reg <= share_m; // RULE_03
      if (wr_go && wa == `JCU_OFF_CEIL)
        ceil_reg <= ceil_m; // RULE_12
      // the index sits where it reads back, in bits 9:8
      if (wr_go && wa == `JCU_OFF_SETSTAT)
        data_idx_reg <= cmd_w[9:8];
    end
  end

  // user sets: last saved channel survives a reinit, not a reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_saved_reg <= 2'b00;
    end else if (save_go) begin
      last_saved_reg <= cmd_w[1:0]; // RULE_18
      if (cmd_w[1:0] != 2'b00) // RULE_15
        for (j = 0; j < NW; j = j + 1)
          set_mem[set_base(cmd_w[1:0]) + j] <=
            config_live[j*32 +: 32]; // RULE_16 RULE_19
    end
  end

  // restore at reset release and on reinit
  always @(posedge aclk) begin
    if (!aresetn) begin
      config_restore <= FACTORY;
      config_restore_load <= 1'b0;
    end else begin
      config_restore_load <= init_pend_reg;
      if (init_pend_reg) begin
        for (i = 0; i < NW; i = i + 1)
          if (last_saved_reg == 2'b00)
            config_restore[i*32 +: 32] <= FACTORY[i*32 +: 32]; // RULE_18
          else
            config_restore[i*32 +: 32] <=
              set_mem[set_base(last_saved_reg) + i]; // RULE_17
      end
    end
  end

  // the automatic engine may ask for more than the ceiling allows; the
  // ceiling wins if it is one percent or more, and a zero after the clamp falls back to the default
  wire [7:0] ceil_pct_w = ceil_pct(ceil_reg);
  wire [7:0] auto_lim = (auto_quality > ceil_pct_w) ?
    ceil_pct_w : auto_quality; // RULE_12
  wire [7:0] auto_eff = (auto_lim == 8'h00) ?
    `JCU_QUAL_ZERO_SUB : auto_lim; // RULE_10

  // effective outputs toward the datapath
  always @(posedge aclk) begin
    if (!aresetn) begin
      compression_enable <= 1'b0;
      rtp_transmit_enable <= 1'b0;
      auto_quality_mode <= 1'b0;
      quality_effective <= `JCU_QUAL_ZERO_SUB;
      buffer_share_effective <= `JCU_SHARE_ZERO_SUB;
      quality_ceiling <= `JCU_CEIL_RESET;
    end else begin
      compression_enable <= on_reg; // RULE_06
      rtp_transmit_enable <= rtp_reg; // RULE_05
      auto_quality_mode <= am_reg; // RULE_08
      quality_ceiling <= ceil_reg; // RULE_12
      buffer_share_effective <= (share_reg == 7'h00) ?
        `JCU_SHARE_ZERO_SUB : share_reg; // RULE_02 RULE_04
      if (am_reg)
        quality_effective <= auto_eff; // RULE_11 RULE_12
      else if (qual_reg == 8'h00)
        quality_effective <= `JCU_QUAL_ZERO_SUB; // RULE_10
      else
        quality_effective <= qual_reg;
    end
  end

  // read channel; one-cycle answer
  reg [31:0] rd;
  always @* begin
    rd = 32'h00000000;
    if (s_axi_araddr == `JCU_OFF_CTRL)
      rd = ctrl_word(rtp_reg, on_reg, am_reg,
        am_reg ? auto_lim : qual_reg); // RULE_01 RULE_08
    else if (s_axi_araddr == `JCU_OFF_SHARE)
      rd = {1'b1, 24'h000000, share_reg}; // RULE_01 RULE_20
    else if (s_axi_araddr == `JCU_OFF_CEIL)
      rd = {1'b1, 24'h000000, ceil_reg}; // RULE_01 RULE_20
    else if (s_axi_araddr == `JCU_OFF_SETSTAT)
      rd = {22'h000000, data_idx_reg, 6'h00, last_saved_reg};
    else if (s_axi_araddr == `JCU_OFF_SETDATA)
      rd = set_mem[set_base(data_idx_reg[0] ? 2'd1 : 2'd2)];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= known_addr(s_axi_araddr) ? OKAY : SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> tb/jcu_regs_properties.sv
// timing checks on the compression register block
// sees only the block's ports; bound into every jcu_regs
`timescale 1ns/10ps
module jcu_props (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // settings
  input wire compression_enable,
  input wire rtp_transmit_enable,
  input wire auto_quality_mode,
  input wire [7:0] quality_effective,
  input wire [6:0] buffer_share_effective,
  input wire [6:0] quality_ceiling,
  input wire config_restore_load
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_pulse;
    config_restore_load ##1 !config_restore_load;
  endsequence
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_share_nonzero: assert property (buffer_share_effective != 7'h00)
    else $error("share zero");
  chk_qual_nonzero: assert property (quality_effective != 8'h00)
    else $error("quality zero");
  chk_off_locks: assert property (!compression_enable |=>
    $stable(rtp_transmit_enable) && $stable(auto_quality_mode))
    else $error("field changed while off");
  chk_ceil_reset: assert property ($rose(aresetn) |->
    quality_ceiling == 7'h66) else $error("ceiling reset");
  chk_boot_load: assert property ($rose(aresetn) |-> ##[1:2] s_pulse)
    else $error("no restore after reset");
endmodule

bind jcu_regs jcu_props u_props (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_bvalid, .s_axi_bready, .compression_enable, .rtp_transmit_enable,
  .auto_quality_mode, .quality_effective, .buffer_share_effective,
  .quality_ceiling, .config_restore_load);

// >>> tb/jcu_regs_test.sv
// self-checking bench for the compression register block
// drives the AXI4-Lite slave and the live config words directly
`timescale 1ns/10ps
`include "jcu_map.vh"
module jcu_regs_test;
  logic aclk = 0, aresetn = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] auto_quality = 8'h2A;
  logic [32*`JCU_NSAVED-1:0] config_live = 0, rst_word = 0;
  wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
  wire s_axi_rvalid, compression_enable, rtp_transmit_enable;
  wire auto_quality_mode, config_restore_load;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] quality_effective;
  wire [6:0] buffer_share_effective, quality_ceiling;
  wire [32*`JCU_NSAVED-1:0] config_restore;
  integer err_count = 0, tests_run = 0, loads = 0, l0;
  logic [31:0] rd_v;
  logic [1:0] rsp;
  jcu_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .auto_quality,
    .compression_enable, .rtp_transmit_enable, .auto_quality_mode,
    .quality_effective, .buffer_share_effective, .quality_ceiling,
    .config_live, .config_restore, .config_restore_load);
  always #50 aclk = ~aclk;
  // restore pulses last one cycle, so they are latched here
  always @(posedge aclk) if (config_restore_load) begin
    loads <= loads + 1;
    rst_word <= config_restore;
  end
  task chk(input string n, input [255:0] s, input [255:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input [15:0] a, input [31:0] d);
    integer n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    if (n >= 50) begin err_count++; wrap_up; end
  endtask
  task rd(input [15:0] a);
    integer n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    if (n >= 50) begin err_count++; wrap_up; end
  endtask
  task reinit;
    integer n;
    l0 = loads;
    wr(`JCU_OFF_SETCMD, 32'h0000_0200);
    for (n = 0; n < 20 && loads == l0; n++) @(posedge aclk);
    if (loads == l0) begin err_count++; wrap_up; end
  endtask
  task t_reset;
    chk("ceil_out", quality_ceiling, 7'h66);
    chk("share_out", buffer_share_effective, 7'h66);
    chk("qual_out", quality_effective, 8'h3C);
    rd(`JCU_OFF_CTRL); chk("ctrl", rd_v, 32'h8000_0000);
    rd(`JCU_OFF_CEIL); chk("ceil", rd_v, 32'h8000_0066);
  endtask
  task t_ctrl;
    wr(`JCU_OFF_CTRL, 32'h4100_0050);
    rd(`JCU_OFF_CTRL); chk("locked", rd_v, 32'h8000_0000);
    wr(`JCU_OFF_CTRL, 32'h4200_0050);
    rd(`JCU_OFF_CTRL); chk("on", rd_v, 32'h8200_0000);
    wr(`JCU_OFF_CTRL, 32'h42FF_FF32);
    rd(`JCU_OFF_CTRL); chk("rsvd", rd_v, 32'hC200_0032);
    chk("rtp", rtp_transmit_enable, 1'b1);
    chk("qual", quality_effective, 8'h32);
    wr(`JCU_OFF_CTRL, 32'h4200_0000);
    @(posedge aclk);
    chk("qual0", quality_effective, 8'h3C);
  endtask
  task t_auto;
    wr(`JCU_OFF_CTRL, 32'h4300_0000);
    rd(`JCU_OFF_CTRL); chk("auto", rd_v, 32'hC300_002A);
    chk("qual_auto", quality_effective, 8'h2A);
    wr(`JCU_OFF_CTRL, 32'h4200_0055);
    rd(`JCU_OFF_CTRL); chk("no_q", rd_v, 32'hC200_0000);
  endtask
  task t_share;
    wr(`JCU_OFF_SHARE, 32'hFFFF_FFFF);
    rd(`JCU_OFF_SHARE); chk("share", rd_v, 32'h8000_007F);
    wr(`JCU_OFF_SHARE, 32'h0000_0000);
    @(posedge aclk);
    chk("share0", buffer_share_effective, 7'h66);
    wr(`JCU_OFF_CEIL, 32'h0000_0050);
    rd(`JCU_OFF_CEIL); chk("ceil_w", rd_v, 32'h8000_0050);
    chk("ceil_o", quality_ceiling, 7'h50);
    // ceiling 0x50 of full scale 0x7F is just under 63 percent
    wr(`JCU_OFF_CTRL, 32'h4300_0000);
    auto_quality <= 8'h64;
    repeat (2) @(posedge aclk);
    chk("clamp", quality_effective, 8'h3E);
    auto_quality <= 8'h2A;
    rd(16'h1E88); chk("bad_r", {rsp, rd_v}, 34'h2_0000_0000);
    wr(16'h1E88, 32'h0000_0001); chk("bad_w", rsp, 2'h2);
  endtask
  task t_sets;
    config_live <= {8{32'hA5A5_0001}};
    wr(`JCU_OFF_SETCMD, 32'h0000_0101);
    config_live <= {8{32'h5A5A_0002}};
    wr(`JCU_OFF_SETCMD, 32'h0000_0102);
    rd(`JCU_OFF_SETSTAT); chk("last", rd_v[1:0], 2'h2);
    wr(`JCU_OFF_SETSTAT, 32'h0000_0100);
    rd(`JCU_OFF_SETDATA); chk("set1", rd_v, 32'hA5A5_0001);
    reinit; chk("load", rst_word, {8{32'h5A5A_0002}});
    wr(`JCU_OFF_SETCMD, 32'h0000_0100);
    rd(`JCU_OFF_SETSTAT); chk("fact", rd_v[1:0], 2'h0);
    reinit; chk("keep", rst_word[31:0] == 32'h5A5A_0002, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_ctrl;
    t_auto;
    t_share;
    t_sets;
    wrap_up;
  end
endmodule
